// File: hw/dmac_params.svh
// constants of the ten-channel dma controller: offsets, field positions, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef DMAC_PARAMS_SVH
`define DMAC_PARAMS_SVH

`define NUM_CH          10
`define REG_ADDR_W      8
`define REG_DATA_W      32
`define BUS_ADDR_W      32
`define BUS_DATA_W      16

// register index inside a channel page, page = REG_ADDR[7:4]
`define REG_CTRL        4'h0
`define REG_SRC         4'h1
`define REG_DST         4'h2
`define REG_COUNT       4'h3
`define REG_SWREQ       4'h4
// global page and its registers
`define PAGE_GLOBAL     4'hF
`define REG_MASK        4'h0
`define REG_PENDING     4'h1
`define REG_BUSY        4'h2

// control register fields
`define CTRL_W          7
`define CTRL_PEND_BIT   7

// request cause select codes
`define CAUSE_SW        2'h0
`define CAUSE_A         2'h1
`define CAUSE_B         2'h2
`define CAUSE_CASCADE   2'h3

// reset values
`define CTRL_RESET      7'h00
`define ADDR_RESET      32'h0000_0000
`define COUNT_RESET     8'h00
`define MASK_RESET      10'h000

// address and count stepping
`define STEP_BYTE       32'h0000_0001
`define STEP_HALF       32'h0000_0002
`define RING_STEP_BYTE  5'h01
`define RING_STEP_HALF  6'h02
`define COUNT_LAST      8'h00
`define COUNT_DEC       8'h01

// byte enables, bit 1 = upper lane = even address
`define BE_NONE         2'h0
`define BE_EVEN         2'h2
`define BE_ODD          2'h1
`define BE_HALF         2'h3

`endif

// File: hw/dmac_pkg.sv
// types shared by the dma controller and its channel slices
// assumes dmac_params.svh on the include path
`include "dmac_params.svh"

package dmac_pkg;

    // bit 0 enable ... bits 6:5 request cause select
    typedef struct packed {
        logic [1:0] request_cause_select;
        logic       ring;
        logic       destination_address_direction;
        logic       source_address_direction;
        logic       transfer_size_select;
        logic       transfer_enable_bit;
    } ctrl_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_GNT,
        ST_READ,
        ST_WRITE
    } xfer_state_e;

    typedef struct packed {
        logic [`BUS_ADDR_W-1:0] addr;
        logic [1:0]             be;
        logic                   rd;
        logic                   wr;
        logic                   req;
    } bus_cmd_s;

endpackage : dmac_pkg

// File: hw/dma_channel.sv
// one dma channel: control, addresses, count and pending request
// assumes decoded write strobes and a one-cycle step pulse from the controller
`timescale 1ns/1ps
`default_nettype none
`include "dmac_params.svh"

module dma_channel
    import dmac_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    wr_en,
    input  wire logic [3:0]              reg_sel,
    input  wire logic [`REG_DATA_W-1:0]  wdata,
    input  wire logic [3:0]              events,
    input  wire logic                    step,
    output var  ctrl_s                   ctrl,
    output var  logic [`BUS_ADDR_W-1:0]  src,
    output var  logic [`BUS_ADDR_W-1:0]  dst,
    output var  logic [7:0]              cnt,
    output var  logic                    pend,
    output wire logic                    done
);

    ////////////////////////////////////////////////////////////////////////////
    // address stepping
    function automatic logic [`BUS_ADDR_W-1:0] next_addr(
        input logic [`BUS_ADDR_W-1:0] a,
        input logic                   inc,
        input logic                   half,
        input logic                   ring
    );
        logic [`BUS_ADDR_W-1:0] r;
        r = a;
        if (inc && ring && half) begin
            r = {a[31:6], a[5:0] + `RING_STEP_HALF};
        end else if (inc && ring) begin
            r = {a[31:5], a[4:0] + `RING_STEP_BYTE};
        end else if (inc) begin
            r = a + (half ? `STEP_HALF : `STEP_BYTE);
        end
        return r;
    endfunction : next_addr

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire logic ctrl_wr  = wr_en && (reg_sel == `REG_CTRL);
    wire logic src_wr   = wr_en && (reg_sel == `REG_SRC);
    wire logic dst_wr   = wr_en && (reg_sel == `REG_DST);
    wire logic cnt_wr   = wr_en && (reg_sel == `REG_COUNT) && !ctrl.transfer_enable_bit;
    wire logic sw_req   = wr_en && (reg_sel == `REG_SWREQ);
    wire ctrl_s wr_ctrl = ctrl_s'(wdata[`CTRL_W-1:0]);

    // cause 0 is the software request, whatever the controller passes in slot 0
    wire logic [3:0] cause_vec = {events[3:1], sw_req};
    wire logic       cause_hit = cause_vec[ctrl.request_cause_select];
    wire logic       pend_set  = ctrl.transfer_enable_bit && cause_hit;
    wire logic       pend_clr  = step || (ctrl_wr && !wdata[`CTRL_PEND_BIT]);
    wire logic       underflow = step && !ctrl.ring && (cnt == `COUNT_LAST);

    assign done = underflow;

    ////////////////////////////////////////////////////////////////////////////
    // state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend <= 1'b0;
        end else if (pend_set) begin
            pend <= 1'b1;
        end else if (pend_clr) begin
            pend <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= ctrl_s'(`CTRL_RESET);
        end else if (ctrl_wr) begin
            ctrl <= wr_ctrl;
        end else if (underflow) begin
            ctrl.transfer_enable_bit <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= `COUNT_RESET;
        end else if (step) begin
            cnt <= cnt - `COUNT_DEC;
        end else if (cnt_wr) begin
            cnt <= wdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src <= `ADDR_RESET;
            dst <= `ADDR_RESET;
        end else begin
            if (src_wr) begin
                src <= wdata;
            end else if (step) begin
                src <= next_addr(src, ctrl.source_address_direction,
                                 ctrl.transfer_size_select, ctrl.ring);
            end
            if (dst_wr) begin
                dst <= wdata;
            end else if (step) begin
                dst <= next_addr(dst, ctrl.destination_address_direction,
                                 ctrl.transfer_size_select, ctrl.ring);
            end
        end
    end

endmodule : dma_channel
`default_nettype wire

// File: hw/ten_channel_dma_controller.sv
// ten-channel single-transfer dma controller with register port and bus master
// assumes a cpu-side bus arbiter giving BUS_GNT and peripherals acking with BUS_ACK
//
// Functional notes
// - cause select picks software write, event a, event b, or previous channel's transfer.
// - a channel starts only once enabled and its cause then fires.
// - lowest numbered requesting channel wins; fixed order, channel 0 highest.
// - arbitration is redone for every transfer slot.
// - take bus, do one read and one write, then release the bus.
// - per-channel size bit chooses 8 or 16 bit units.
// - count decrements by one per unit; up to 256 transfers.
// - read lands in a holding register; the write sends it on.
// - bus signalling matches the cpu's peripheral accesses.
// - fixed addresses stay; incrementing ones step by 1 or 2.
// - byte units honour address bit 0 on both sides.
// - halfword units ignore address bit 0 and move aligned halfwords.
// - ring mode wraps to the start address after 32 transfers.
// - ring byte mode steps the low five bits by one, wrapping.
// - ring halfword mode steps the low six bits by two, wrapping.
// - only incrementing addresses wrap; both wrap together when both increment.
// - ring mode ignores the count, runs until enable is cleared.
// - normal mode stops on underflow, clears enable, raises completion unless masked.
// - count writes are ignored while the channel is enabled.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dmac_params.svh"

module ten_channel_dma_controller
    import dmac_pkg::*;
#(
    parameter int NCH = `NUM_CH
)
(
    input  wire logic                    CORE_CLK,
    input  wire logic                    RST_N,
    input  wire logic [`REG_ADDR_W-1:0]  REG_ADDR,
    input  wire logic [`REG_DATA_W-1:0]  REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output var  logic [`REG_DATA_W-1:0]  REG_RDATA,
    input  wire logic [NCH-1:0]          CAUSE_A,
    input  wire logic [NCH-1:0]          CAUSE_B,
    input  wire logic                    CASCADE0,
    input  wire logic                    BUS_GNT,
    input  wire logic                    BUS_ACK,
    input  wire logic [`BUS_DATA_W-1:0]  BUS_RDATA,
    output wire logic                    BUS_REQ,
    output wire logic [`BUS_ADDR_W-1:0]  BUS_ADDR,
    output wire logic                    BUS_RD,
    output wire logic                    BUS_WR,
    output wire logic [1:0]              BUS_BE,
    output var  logic [`BUS_DATA_W-1:0]  BUS_WDATA,
    output var  logic [NCH-1:0]          COMPLETE_REQ
);

    ////////////////////////////////////////////////////////////////////////////
    // register decode
    wire logic [3:0] page    = REG_ADDR[7:4];
    wire logic [3:0] reg_sel = REG_ADDR[3:0];
    wire logic       page_ok = (page < 4'(NCH));
    wire logic       glob    = (page == `PAGE_GLOBAL);

    ctrl_s                   ch_ctrl [NCH];
    logic [`BUS_ADDR_W-1:0]  ch_src  [NCH];
    logic [`BUS_ADDR_W-1:0]  ch_dst  [NCH];
    logic [7:0]              ch_cnt  [NCH];
    logic [NCH-1:0]          ch_pend;
    logic [NCH-1:0]          ch_req;
    logic [NCH-1:0]          ch_done;
    logic [NCH-1:0]          step_vec;
    logic [NCH-1:0]          cascade_in;
    logic [NCH-1:0]          mask_reg;

    xfer_state_e             state_reg;
    bus_cmd_s                bus_reg;
    logic [3:0]              cur_ch_reg;

    ////////////////////////////////////////////////////////////////////////////
    // channel slices
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            if (g == 0) begin : gen_first
                assign cascade_in[g] = CASCADE0;
            end else begin : gen_rest
                assign cascade_in[g] = step_vec[g-1];
            end

            wire logic ch_wr = REG_WR && page_ok && (page == 4'(g));

            dma_channel u_ch (
                .clk     (CORE_CLK),
                .rst_n   (RST_N),
                .wr_en   (ch_wr),
                .reg_sel (reg_sel),
                .wdata   (REG_WDATA),
                .events  ({cascade_in[g], CAUSE_B[g], CAUSE_A[g], 1'b0}),
                .step    (step_vec[g]),
                .ctrl    (ch_ctrl[g]),
                .src     (ch_src[g]),
                .dst     (ch_dst[g]),
                .cnt     (ch_cnt[g]),
                .pend    (ch_pend[g]),
                .done    (ch_done[g])
            );

            assign ch_req[g]   = ch_pend[g] && ch_ctrl[g].transfer_enable_bit;
            assign step_vec[g] = (state_reg == ST_WRITE) && BUS_ACK
                                 && (cur_ch_reg == 4'(g));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // fixed priority arbiter, lowest index wins
    logic [3:0] grant_idx;
    logic       any_req;

    always_comb begin
        grant_idx = 4'h0;
        any_req   = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (ch_req[i]) begin
                grant_idx = 4'(i);
                any_req   = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // addresses, lanes and holding data for the granted channel
    ctrl_s                  cur_ctrl;
    logic [`BUS_ADDR_W-1:0] cur_src;
    logic [`BUS_ADDR_W-1:0] cur_dst;

    assign cur_ctrl = ch_ctrl[cur_ch_reg];
    assign cur_src  = ch_src[cur_ch_reg];
    assign cur_dst  = ch_dst[cur_ch_reg];

    wire logic                   half     = cur_ctrl.transfer_size_select;
    wire logic [`BUS_ADDR_W-1:0] rd_addr  = half ? {cur_src[31:1], 1'b0}
                                                 : cur_src;
    wire logic [`BUS_ADDR_W-1:0] wr_addr  = half ? {cur_dst[31:1], 1'b0}
                                                 : cur_dst;
    wire logic [1:0]             rd_be    = half ? `BE_HALF
                                          : (cur_src[0] ? `BE_ODD : `BE_EVEN);
    wire logic [1:0]             wr_be    = half ? `BE_HALF
                                          : (cur_dst[0] ? `BE_ODD : `BE_EVEN);
    wire logic [7:0]             rd_byte  = cur_src[0] ? BUS_RDATA[7:0]
                                                       : BUS_RDATA[15:8];
    // a byte is copied onto both lanes; the byte enable picks the live one
    wire logic [`BUS_DATA_W-1:0] hold_next = half ? BUS_RDATA : {rd_byte, rd_byte};

    ////////////////////////////////////////////////////////////////////////////
    // transfer sequencer: request, read, write, release
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_reg  <= ST_IDLE;
            bus_reg    <= '0;
            cur_ch_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (any_req) begin
                        cur_ch_reg  <= grant_idx;
                        bus_reg.req <= 1'b1;
                        state_reg   <= ST_WAIT_GNT;
                    end
                end
                ST_WAIT_GNT: begin
                    if (BUS_GNT) begin
                        bus_reg.addr <= rd_addr;
                        bus_reg.be   <= rd_be;
                        bus_reg.rd   <= 1'b1;
                        state_reg    <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (BUS_ACK) begin
                        bus_reg.rd   <= 1'b0;
                        bus_reg.addr <= wr_addr;
                        bus_reg.be   <= wr_be;
                        bus_reg.wr   <= 1'b1;
                        state_reg    <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (BUS_ACK) begin
                        bus_reg   <= '0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    bus_reg   <= '0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // holding register, also the write data driver
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            BUS_WDATA <= '0;
        end else if ((state_reg == ST_READ) && BUS_ACK) begin
            BUS_WDATA <= hold_next;
        end
    end

    assign BUS_REQ  = bus_reg.req;
    assign BUS_ADDR = bus_reg.addr;
    assign BUS_RD   = bus_reg.rd;
    assign BUS_WR   = bus_reg.wr;
    assign BUS_BE   = bus_reg.be;

    ////////////////////////////////////////////////////////////////////////////
    // completion requests and mask
    wire logic mask_wr = REG_WR && glob && (reg_sel == `REG_MASK);

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            mask_reg     <= `MASK_RESET;
            COMPLETE_REQ <= '0;
        end else begin
            if (mask_wr) begin
                mask_reg <= REG_WDATA[NCH-1:0];
            end
            COMPLETE_REQ <= ch_done & ~mask_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read path, data valid the cycle after the strobe
    logic [`REG_DATA_W-1:0] ch_rdata;
    logic [`REG_DATA_W-1:0] glob_rdata;
    logic [`REG_DATA_W-1:0] rdata_next;

    always_comb begin
        ch_rdata = '0;
        if (page_ok) begin
            case (reg_sel)
                `REG_CTRL:  ch_rdata = {24'h00_0000, ch_pend[page], ch_ctrl[page]};
                `REG_SRC:   ch_rdata = ch_src[page];
                `REG_DST:   ch_rdata = ch_dst[page];
                `REG_COUNT: ch_rdata = {24'h00_0000, ch_cnt[page]};
                default:    ch_rdata = '0;
            endcase
        end
    end

    always_comb begin
        glob_rdata = '0;
        case (reg_sel)
            `REG_MASK:    glob_rdata[NCH-1:0] = mask_reg;
            `REG_PENDING: glob_rdata[NCH-1:0] = ch_pend;
            `REG_BUSY:    glob_rdata[4:0]     = {state_reg != ST_IDLE, cur_ch_reg};
            default:      glob_rdata          = '0;
        endcase
    end

    assign rdata_next = !REG_RD ? '0 : (glob ? glob_rdata : ch_rdata);

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            REG_RDATA <= '0;
        end else begin
            REG_RDATA <= rdata_next;
        end
    end

endmodule : ten_channel_dma_controller
`default_nettype wire

// File: dv/ten_channel_dma_controller_properties.sv
// bus master and completion checks for the dma controller
// assumes binding onto the top module, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "dmac_params.svh"

module ten_channel_dma_controller_properties #(
    parameter int NCH = 10
) (
    input wire logic                   CORE_CLK,
    input wire logic                   RST_N,
    input wire logic                   BUS_GNT,
    input wire logic                   BUS_ACK,
    input wire logic                   BUS_REQ,
    input wire logic [`BUS_ADDR_W-1:0] BUS_ADDR,
    input wire logic                   BUS_RD,
    input wire logic                   BUS_WR,
    input wire logic [1:0]             BUS_BE,
    input wire logic [`BUS_DATA_W-1:0] BUS_WDATA,
    input wire logic [NCH-1:0]         COMPLETE_REQ
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence rd_done; BUS_RD && BUS_ACK; endsequence
    sequence wr_phase; !BUS_RD && BUS_WR && BUS_REQ; endsequence
    sequence wr_done; BUS_WR && BUS_ACK; endsequence

    a_rd_to_wr: assert property (rd_done |=> wr_phase)
        else $error("no write after read");
    a_rd_after_gnt: assert property ($rose(BUS_RD) |-> BUS_REQ && $past(BUS_GNT))
        else $error("read without grant");
    a_rd_hold: assert property (BUS_RD && !BUS_ACK |=> BUS_RD && $stable(BUS_ADDR))
        else $error("read dropped early");
    a_wr_hold: assert property (BUS_WR && !BUS_ACK |=> BUS_WR && $stable(BUS_WDATA))
        else $error("write dropped early");
    a_bus_release: assert property (wr_done |=> !BUS_REQ && !BUS_WR && !BUS_RD)
        else $error("bus kept after write");
    a_idle_gap: assert property ($fell(BUS_REQ) |-> $past(BUS_WR && BUS_ACK))
        else $error("bus dropped early");
    a_half_align: assert property ((BUS_RD || BUS_WR) && BUS_BE == `BE_HALF
        |-> !BUS_ADDR[0]) else $error("odd halfword");
    a_byte_lane: assert property ((BUS_RD || BUS_WR) && BUS_BE != `BE_HALF
        |-> BUS_BE == (BUS_ADDR[0] ? `BE_ODD : `BE_EVEN)) else $error("byte lane wrong");
    a_done_after_wr: assert property (COMPLETE_REQ != '0
        |-> $past(BUS_WR && BUS_ACK) && !BUS_REQ) else $error("stray completion");
endmodule : ten_channel_dma_controller_properties

bind ten_channel_dma_controller ten_channel_dma_controller_properties #(.NCH(NCH)) props_inst (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .BUS_GNT(BUS_GNT), .BUS_ACK(BUS_ACK),
    .BUS_REQ(BUS_REQ), .BUS_ADDR(BUS_ADDR), .BUS_RD(BUS_RD), .BUS_WR(BUS_WR),
    .BUS_BE(BUS_BE), .BUS_WDATA(BUS_WDATA), .COMPLETE_REQ(COMPLETE_REQ)
);
`default_nettype wire

// File: dv/bus_slave_model.sv
// internal bus partner: grants the bus, answers after a set delay
// assumes one dma master, 16-bit bus, even byte on the upper lane
`timescale 1ns/1ps
`default_nettype none

module bus_slave_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        req,
    input  wire logic        rd,
    input  wire logic        wr,
    input  wire logic [31:0] addr,
    input  wire logic [1:0]  be,
    input  wire logic [15:0] wdata,
    input  wire logic [3:0]  lat,
    output logic             gnt,
    output logic             ack,
    output logic [15:0]      rdata,
    output logic [31:0]      raddr,
    output logic [31:0]      waddr,
    output logic [15:0]      wval,
    output logic [1:0]       wbe,
    output logic [15:0]      wcnt
);
    logic [3:0] wait_reg;
    // every byte reads back as the low byte of its own address
    wire logic [15:0] hw = {addr[7:1], 1'b0, addr[7:1], 1'b1};
    wire logic        go = (rd || wr) && !ack && wait_reg >= lat;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gnt      <= 1'b0;
            ack      <= 1'b0;
            rdata    <= 16'h0000;
            wait_reg <= 4'h0;
            wcnt     <= 16'h0000;
        end else begin
            gnt      <= req;
            ack      <= go;
            wait_reg <= (go || ack || !(rd || wr)) ? 4'h0 : wait_reg + 4'h1;
            // released data lines show the inverse
            rdata    <= (go && rd) ? hw : ~rdata;
            if (go && rd) raddr <= addr;
            if (go && wr) begin
                waddr <= addr;
                wval  <= wdata;
                wbe   <= be;
                wcnt  <= wcnt + 16'h0001;
            end
        end
    end
endmodule : bus_slave_model
`default_nettype wire

// File: dv/ten_channel_dma_controller_tb_top.sv
// self-checking bench for the ten-channel dma controller
// assumes the bus partner model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "dmac_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module ten_channel_dma_controller_tb_top
    import dmac_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, m_raddr, m_waddr, b_addr;
    logic [9:0]  cause_a = 10'h000, cause_b = 10'h000, done_seen = 10'h000, cmp;
    logic        gnt, ack, req, brd, bwr;
    logic [15:0] b_rdata, b_wdata, m_wval, m_wcnt;
    logic [1:0]  b_be, m_wbe;
    logic [3:0]  lat = 4'h0;
    int          n_fail = 0, checked = 0;

    always #5 clk = ~clk;
    always @(posedge clk) done_seen <= done_seen | cmp;

    ten_channel_dma_controller ten_channel_dma_controller_inst (
        .CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .CAUSE_A(cause_a),
        .CAUSE_B(cause_b), .CASCADE0(cause_a[0]), .BUS_GNT(gnt), .BUS_ACK(ack),
        .BUS_RDATA(b_rdata), .BUS_REQ(req), .BUS_ADDR(b_addr), .BUS_RD(brd), .BUS_WR(bwr),
        .BUS_BE(b_be), .BUS_WDATA(b_wdata), .COMPLETE_REQ(cmp));
    bus_slave_model bus_slave_model_inst (
        .clk(clk), .rst_n(rst_n), .req(req), .rd(brd), .wr(bwr), .addr(b_addr), .be(b_be),
        .wdata(b_wdata), .lat(lat), .gnt(gnt), .ack(ack), .rdata(b_rdata), .raddr(m_raddr),
        .waddr(m_waddr), .wval(m_wval), .wbe(m_wbe), .wcnt(m_wcnt));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    function automatic logic [7:0] ra(input logic [3:0] ch, input logic [3:0] idx);
        return {ch, idx};
    endfunction : ra
    // flags: ring, dst inc, src inc, size16, enable
    function automatic logic [31:0] cw(input logic [1:0] c, input logic [4:0] f);
        return {25'h000_0000, c, f};
    endfunction : cw
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic pulse(input logic b, input logic [9:0] m);
        @(posedge clk);
        cause_a <= b ? 10'h000 : m;
        cause_b <= b ? m : 10'h000;
        @(posedge clk);
        cause_a <= 10'h000;
        cause_b <= 10'h000;
    endtask : pulse
    task automatic wait_wr(input logic [15:0] n);
        int i;
        for (i = 0; i < 300 && m_wcnt !== n; i++) @(posedge clk);
        if (m_wcnt !== n) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, m_wcnt, n);
            end_sim();
        end
        repeat (2) @(posedge clk);
    endtask : wait_wr
    task automatic setup(input logic [3:0] ch, input logic [31:0] s, d, n, c);
        wr(ra(ch, `REG_SRC), s);
        wr(ra(ch, `REG_DST), d);
        wr(ra(ch, `REG_COUNT), n);
        wr(ra(ch, `REG_CTRL), c);
    endtask : setup

    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_byte;
        logic [31:0] v;
        logic [15:0] b;
        b = m_wcnt;
        rd(8'hA0, v);
        `CHK(v, 32'h0000_0000)
        setup(4'h9, 32'h0080_1001, 32'h0080_2000, 32'h0000_0001, cw(`CAUSE_SW, 5'h0C));
        wr(ra(4'h9, `REG_SWREQ), 32'h0000_0000);
        wr(ra(4'h9, `REG_CTRL), cw(`CAUSE_SW, 5'h0D));
        wr(ra(4'h9, `REG_COUNT), 32'h0000_0005);
        rd(ra(4'h9, `REG_COUNT), v);
        `CHK(v, 32'h0000_0001)
        `CHK(m_wcnt, b)
        wr(ra(4'h9, `REG_SWREQ), 32'h0000_0000);
        wait_wr(b + 16'h0001);
        `CHK({m_raddr, m_waddr}, {32'h0080_1001, 32'h0080_2000})
        `CHK({m_wval, m_wbe}, {16'h0101, `BE_EVEN})
        wr(ra(4'h9, `REG_SWREQ), 32'h0000_0000);
        wait_wr(b + 16'h0002);
        `CHK({m_waddr, m_wval, m_wbe}, {32'h0080_2001, 16'h0202, `BE_ODD})
        `CHK(done_seen[9], 1'b1)
        rd(ra(4'h9, `REG_COUNT), v);
        `CHK(v, 32'h0000_00FF)
        rd(ra(4'h9, `REG_CTRL), v);
        `CHK(v[0], 1'b0)
        $display("byte test done");
    endtask : s_byte
    task automatic s_half;
        logic [31:0] v;
        logic [15:0] b;
        lat <= 4'h3;
        wr(ra(4'hF, `REG_MASK), 32'h0000_0008);
        setup(4'h3, 32'h0080_0011, 32'h0080_3000, 32'h0000_0000, cw(`CAUSE_A, 5'h0A));
        b = m_wcnt;
        pulse(1'b0, 10'h008);
        wr(ra(4'h3, `REG_CTRL), cw(`CAUSE_A, 5'h0B));
        repeat (10) @(posedge clk);
        `CHK(m_wcnt, b)
        pulse(1'b0, 10'h008);
        wait_wr(b + 16'h0001);
        `CHK({m_raddr, m_waddr}, {32'h0080_0010, 32'h0080_3000})
        `CHK({m_wval, m_wbe}, {16'h1011, `BE_HALF})
        rd(ra(4'h3, `REG_SRC), v);
        `CHK(v, 32'h0080_0011)
        rd(ra(4'h3, `REG_DST), v);
        `CHK(v, 32'h0080_3002)
        `CHK(done_seen[3], 1'b0)
        $display("half test done");
    endtask : s_half
    task automatic s_ring(input logic sz);
        logic [31:0] a31;
        logic [15:0] b;
        int i;
        lat <= {3'h0, sz};
        setup(4'h0, 32'h0080_0040, 32'h0080_1000, 32'h0000_0000,
              cw(sz ? `CAUSE_CASCADE : `CAUSE_B, {3'h6, sz, 1'h1}));
        b = m_wcnt;
        for (i = 1; i <= 33; i++) begin
            pulse(!sz, 10'h001);
            wait_wr(b + i[15:0]);
            if (i == 32) a31 = m_waddr;
        end
        `CHK(a31, sz ? 32'h0080_103E : 32'h0080_101F)
        `CHK(m_waddr, 32'h0080_1000)
        `CHK(m_raddr, 32'h0080_0040)
        wr(ra(4'h0, `REG_CTRL), cw(`CAUSE_B, {3'h6, sz, 1'h0}));
        `CHK(done_seen[0], 1'b0)
        $display("ring test done");
    endtask : s_ring
    task automatic s_prio;
        logic [15:0] b;
        lat <= 4'h0;
        setup(4'h2, 32'h0080_0020, 32'h0080_4002, 32'h0000_0010, cw(`CAUSE_A, 5'h01));
        setup(4'h5, 32'h0080_0020, 32'h0080_4005, 32'h0000_0010, cw(`CAUSE_A, 5'h01));
        setup(4'h6, 32'h0080_0020, 32'h0080_4006, 32'h0000_0010, cw(`CAUSE_CASCADE, 5'h01));
        b = m_wcnt;
        pulse(1'b0, 10'h024);
        wait_wr(b + 16'h0001);
        `CHK(m_waddr, 32'h0080_4002)
        wait_wr(b + 16'h0002);
        `CHK(m_waddr, 32'h0080_4005)
        wait_wr(b + 16'h0003);
        `CHK(m_waddr, 32'h0080_4006)
        repeat (20) @(posedge clk);
        `CHK({m_wcnt, m_wval}, {b + 16'h0003, 16'h2020})
        $display("priority test done");
    endtask : s_prio

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        s_byte();
        s_half();
        s_ring(1'b0);
        s_ring(1'b1);
        s_prio();
        end_sim();
    end
endmodule : ten_channel_dma_controller_tb_top
`default_nettype wire
